/* File: core/ifc_pkg.sv */
// Constants for the interrupt flag and edge control block
`default_nettype none
// How it works
// - Control bit 15 set selects the alternate vector table, clear the standard one.
// - Control bit 14 reads 1 while a disable-interrupts instruction runs, else 0, reset 0.
// - Control bits 13 to 5 always read zero.
// - Control bits 4 to 0 are the edge polarity bits of external inputs 4 to 0.
// - Polarity 1 raises the request on a falling edge, polarity 0 on a rising edge.
// - A flag bit reads 1 once its source has requested, 0 while none has.
// - All implemented bits reset to 0 and are read/write, except the status bit.
// - Flags 0: bit 15 zero; 14..8 dma1, adc1, uart1 tx, uart1 rx, spi1, spi1 fault, timer3.
// - Flags 0: 7..0 timer2, compare2, capture2, dma0, timer1, compare1, capture1, ext0.
// - Flags 1: 15..8 uart2 tx, uart2 rx, ext2, timer5, timer4, compare4, compare3, dma2.
// - Flags 1: 7..3 capture8, capture7, adc2, ext1, change notice; 2 zero; 1..0 i2c1.
// - Flags 2: 15 timer6, 14 dma4, 13 zero, 12..9 compare 8 to 5.
// - Flags 2: 8..5 capture 6 to 3, 4 dma3, 3 can1 event.
// - Flags 2: 2 can1 receive ready, 1 spi2 event, 0 spi2 error.
package ifc_pkg;
    // ==================================================
    // Register indices on the plain register port
    localparam logic [2:0] OFS_CTRL   = 3'h0;
    localparam logic [2:0] OFS_FLAGS0 = 3'h1;
    localparam logic [2:0] OFS_FLAGS1 = 3'h2;
    localparam logic [2:0] OFS_FLAGS2 = 3'h3;
    localparam logic [2:0] OFS_MASK0  = 3'h4;
    localparam logic [2:0] OFS_MASK1  = 3'h5;
    localparam logic [2:0] OFS_MASK2  = 3'h6;
    // ==================================================
    // Control register field positions
    localparam int CTRL_ALT_BIT  = 15;
    localparam int CTRL_DIS_BIT  = 14;
    localparam int NUM_EXT       = 5;
    // ==================================================
    // Implemented bits of each flag register
    localparam logic [15:0] IMPL_FLAGS0 = 16'h7FFF;
    localparam logic [15:0] IMPL_FLAGS1 = 16'hFFFB;
    localparam logic [15:0] IMPL_FLAGS2 = 16'hDFFF;
    // Positions of the external request flags
    localparam int EXT0_FLAG_BIT = 0;
    localparam int EXT1_FLAG_BIT = 4;
    localparam int EXT2_FLAG_BIT = 13;
    // ==================================================
    // Reset values
    localparam logic [15:0] RST_FLAGS = 16'h0000;
    localparam logic [15:0] RST_MASK  = 16'h0000;
    localparam logic [4:0]  RST_POL   = 5'h00;
    localparam logic        RST_ALT   = 1'b0;
endpackage : ifc_pkg
`default_nettype wire

/* File: core/ifc_flag_ctrl.sv */
// Interrupt control, edge polarity and flag status registers
//
// Decided for this implementation: strobed register access and the register offsets.
`default_nettype none
module ifc_flag_ctrl (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Core side
    input  wire logic        irq_disable_active,
    output logic             alternate_table_select,
    output logic             irq,
    // External interrupt pins, asynchronous
    input  wire logic [4:0]  ext_irq_pin,
    output logic      [4:0]  ext_irq_edge,
    // Peripheral requests, one-cycle pulses
    input  wire logic [15:0] periph_req0,
    input  wire logic [15:0] periph_req1,
    input  wire logic [15:0] periph_req2
);

    // ==================================================
    // State
    typedef struct packed {
        logic             alt;
        logic             dis_status;
        logic [4:0]       pol;
        logic [2:0][15:0] flags;
        logic [2:0][15:0] mask;
        logic [4:0]       sync1;
        logic [4:0]       sync2;
        logic [4:0]       prev;
        logic [15:0]      rdata;
    } ifc_state_t;

    ifc_state_t s_q;
    ifc_state_t s_d;

    // ==================================================
    // Edge detection per external input
    logic [4:0] edge_hit;

    genvar g;
    generate
        for (g = 0; g < ifc_pkg::NUM_EXT; g++) begin : g_edge
            logic rise;
            logic fall;
            // Only the second sync stage is looked at
            assign rise = s_q.sync2[g] & ~s_q.prev[g];
            assign fall = ~s_q.sync2[g] & s_q.prev[g];
            // Polarity 1 picks the falling edge
            assign edge_hit[g] = s_q.pol[g] ? fall : rise;
        end
    endgenerate

    // ==================================================
    // Request vectors per flag register
    logic [2:0][15:0] req;
    logic [2:0][15:0] impl;
    logic [2:0]       wr_hit;

    always_comb begin
        impl[0] = ifc_pkg::IMPL_FLAGS0;
        impl[1] = ifc_pkg::IMPL_FLAGS1;
        impl[2] = ifc_pkg::IMPL_FLAGS2;
        req[0] = periph_req0;
        req[1] = periph_req1;
        req[2] = periph_req2;
        // External flags come from the edge logic only
        req[0][ifc_pkg::EXT0_FLAG_BIT] =
            edge_hit[0];
        req[1][ifc_pkg::EXT1_FLAG_BIT] =
            edge_hit[1];
        req[1][ifc_pkg::EXT2_FLAG_BIT] =
            edge_hit[2];
        wr_hit[0] = reg_wr
            && (reg_addr == ifc_pkg::OFS_FLAGS0);
        wr_hit[1] = reg_wr
            && (reg_addr == ifc_pkg::OFS_FLAGS1);
        wr_hit[2] = reg_wr
            && (reg_addr == ifc_pkg::OFS_FLAGS2);
    end

    // ==================================================
    // Next state
    logic [15:0] ctrl_view;

    always_comb begin
        ctrl_view = 16'h0000;
        ctrl_view[ifc_pkg::CTRL_ALT_BIT] = s_q.alt;
        ctrl_view[ifc_pkg::CTRL_DIS_BIT] =
            s_q.dis_status;
        ctrl_view[4:0] = s_q.pol;
    end

    always_comb begin
        s_d = s_q;
        // Two-stage synchroniser on the pins
        s_d.sync1 = ext_irq_pin;
        s_d.sync2 = s_q.sync1;
        s_d.prev  = s_q.sync2;
        // Status bit follows the core, not writable
        s_d.dis_status = irq_disable_active;
        if (reg_wr && reg_addr == ifc_pkg::OFS_CTRL) begin
            s_d.alt = reg_wdata[ifc_pkg::CTRL_ALT_BIT];
            s_d.pol = reg_wdata[4:0];
        end
        for (int i = 0; i < 3; i++) begin
            // Write stores ones and zeros; set wins
            if (wr_hit[i]) begin
                s_d.flags[i] = reg_wdata & impl[i];
            end
            s_d.flags[i] = s_d.flags[i]
                | (req[i] & impl[i]);
        end
        if (reg_wr && reg_addr == ifc_pkg::OFS_MASK0) begin
            s_d.mask[0] = reg_wdata & impl[0];
        end
        if (reg_wr && reg_addr == ifc_pkg::OFS_MASK1) begin
            s_d.mask[1] = reg_wdata & impl[1];
        end
        if (reg_wr && reg_addr == ifc_pkg::OFS_MASK2) begin
            s_d.mask[2] = reg_wdata & impl[2];
        end
        // Read data stand only in the cycle after
        s_d.rdata = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                ifc_pkg::OFS_CTRL: begin
                    s_d.rdata = ctrl_view;
                end
                ifc_pkg::OFS_FLAGS0: begin
                    s_d.rdata = s_q.flags[0];
                end
                ifc_pkg::OFS_FLAGS1: begin
                    s_d.rdata = s_q.flags[1];
                end
                ifc_pkg::OFS_FLAGS2: begin
                    s_d.rdata = s_q.flags[2];
                end
                ifc_pkg::OFS_MASK0: begin
                    s_d.rdata = s_q.mask[0];
                end
                ifc_pkg::OFS_MASK1: begin
                    s_d.rdata = s_q.mask[1];
                end
                ifc_pkg::OFS_MASK2: begin
                    s_d.rdata = s_q.mask[2];
                end
                // Unmapped index reads as zero
                default: begin
                    s_d.rdata = 16'h0000;
                end
            endcase
        end
    end

    // ==================================================
    // State register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q.alt   <= ifc_pkg::RST_ALT;
            s_q.dis_status <= 1'b0;
            s_q.pol   <= ifc_pkg::RST_POL;
            s_q.flags <= {3{ifc_pkg::RST_FLAGS}};
            s_q.mask  <= {3{ifc_pkg::RST_MASK}};
            s_q.sync1 <= 5'h00;
            s_q.sync2 <= 5'h00;
            s_q.prev  <= 5'h00;
            s_q.rdata <= 16'h0000;
        end else begin
            s_q <= s_d;
        end
    end

    // ==================================================
    // Outputs
    assign reg_rdata = s_q.rdata;
    assign alternate_table_select = s_q.alt;
    // Edge pulse lets ext 3 and 4 reach flags held elsewhere
    assign ext_irq_edge = edge_hit;
    // Level interrupt while any unmasked flag is set
    assign irq = |((s_q.flags[0] & s_q.mask[0])
                 | (s_q.flags[1] & s_q.mask[1])
                 | (s_q.flags[2] & s_q.mask[2]));

    // ==================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    alt_follows_write_a : assert property (
        reg_wr && reg_addr == ifc_pkg::OFS_CTRL
        |=> alternate_table_select
            == $past(reg_wdata[ifc_pkg::CTRL_ALT_BIT]))
    else $error("Alternate table select did not follow write");

    dis_status_a : assert property (
        reg_rd && reg_addr == ifc_pkg::OFS_CTRL
        ##0 $past(irq_disable_active)
        |=> reg_rdata[ifc_pkg::CTRL_DIS_BIT])
    else $error("Disable status bit not reported");

    ctrl_unimpl_a : assert property (
        reg_rd && reg_addr == ifc_pkg::OFS_CTRL
        |=> reg_rdata[13:5] == 9'h000)
    else $error("Unimplemented control bits not zero");

    edge_sets_flag_a : assert property (
        $rose(s_q.sync2[0]) && !s_q.pol[0]
        && !(reg_wr && reg_addr == ifc_pkg::OFS_CTRL)
        |=> s_q.flags[0][ifc_pkg::EXT0_FLAG_BIT])
    else $error("Rising edge did not set ext0 flag");

    fall_edge_flag_a : assert property (
        $fell(s_q.sync2[1]) && s_q.pol[1]
        && !(reg_wr && reg_addr == ifc_pkg::OFS_CTRL)
        |=> s_q.flags[1][ifc_pkg::EXT1_FLAG_BIT])
    else $error("Falling edge did not set ext1 flag");

    set_beats_clear_a : assert property (
        wr_hit[1] && periph_req1[15]
        |=> s_q.flags[1][15])
    else $error("Clear won over a same-cycle set");

    flag_sticky_a : assert property (
        s_q.flags[2][15] && !wr_hit[2]
        |=> s_q.flags[2][15] [*1])
    else $error("Flag dropped without a write");

    unimpl_flags_a : assert property (
        s_q.flags[0][15] == 1'b0
        && s_q.flags[1][2] == 1'b0
        && s_q.flags[2][13] == 1'b0)
    else $error("Unimplemented flag bit set");

    read_one_cycle_a : assert property (
        !reg_rd |=> reg_rdata == 16'h0000)
    else $error("Read data present without a read");

    irq_level_a : assert property (
        (s_q.flags[0][3] && s_q.mask[0][3]) |-> irq)
    else $error("Unmasked flag did not raise irq");

    alt_hold_a : assert property (
        !(reg_wr && reg_addr == ifc_pkg::OFS_CTRL)
        |=> $stable(alternate_table_select))
    else $error("Alternate table select moved without a write");

    pol_write_a : assert property (
        reg_wr && reg_addr == ifc_pkg::OFS_CTRL
        |=> s_q.pol == $past(reg_wdata[4:0]))
    else $error("Polarity bits did not follow write");

    pol_hold_a : assert property (
        !(reg_wr && reg_addr == ifc_pkg::OFS_CTRL)
        |=> $stable(s_q.pol))
    else $error("Polarity bits moved without a write");

    dis_set_a : assert property (
        irq_disable_active |=> s_q.dis_status)
    else $error("Disable status not raised");

    dis_clear_a : assert property (
        !irq_disable_active |=> !s_q.dis_status)
    else $error("Disable status not cleared");

    dis_read_low_a : assert property (
        reg_rd && reg_addr == ifc_pkg::OFS_CTRL
        ##0 !$past(irq_disable_active)
        |=> !reg_rdata[ifc_pkg::CTRL_DIS_BIT])
    else $error("Disable status read high while idle");

    pol_read_a : assert property (
        reg_rd && reg_addr == ifc_pkg::OFS_CTRL
        |=> reg_rdata[4:0] == $past(s_q.pol))
    else $error("Polarity bits read wrong");

    alt_read_a : assert property (
        reg_rd && reg_addr == ifc_pkg::OFS_CTRL
        |=> reg_rdata[ifc_pkg::CTRL_ALT_BIT] == $past(s_q.alt))
    else $error("Alternate table bit read wrong");

    flags0_read_a : assert property (
        reg_rd && reg_addr == ifc_pkg::OFS_FLAGS0
        |=> reg_rdata == $past(s_q.flags[0]))
    else $error("Flag register 0 read wrong");

    flags1_read_a : assert property (
        reg_rd && reg_addr == ifc_pkg::OFS_FLAGS1
        |=> reg_rdata == $past(s_q.flags[1]))
    else $error("Flag register 1 read wrong");

    flags2_read_a : assert property (
        reg_rd && reg_addr == ifc_pkg::OFS_FLAGS2
        |=> reg_rdata == $past(s_q.flags[2]))
    else $error("Flag register 2 read wrong");

    dma0_set_a : assert property (
        periph_req0[4] |=> s_q.flags[0][4])
    else $error("Channel 0 done request not flagged");

    dma1_set_a : assert property (
        periph_req0[14] |=> s_q.flags[0][14])
    else $error("Channel 1 done request not flagged");

    i2c_slave_set_a : assert property (
        periph_req1[0] |=> s_q.flags[1][0])
    else $error("Serial slave request not flagged");

    can_rx_set_a : assert property (
        periph_req2[2] |=> s_q.flags[2][2])
    else $error("Receive ready request not flagged");

    capture3_set_a : assert property (
        periph_req2[5] |=> s_q.flags[2][5])
    else $error("Capture 3 request not flagged");

    timer6_set_a : assert property (
        periph_req2[15] |=> s_q.flags[2][15])
    else $error("Timer 6 request not flagged");

    ext0_pin_only_a : assert property (
        periph_req0[ifc_pkg::EXT0_FLAG_BIT] && !edge_hit[0]
        && !wr_hit[0] && !s_q.flags[0][ifc_pkg::EXT0_FLAG_BIT]
        |=> !s_q.flags[0][ifc_pkg::EXT0_FLAG_BIT])
    else $error("Ext 0 flag set without a pin edge");

    ext2_flag_a : assert property (
        edge_hit[2] |=> s_q.flags[1][ifc_pkg::EXT2_FLAG_BIT])
    else $error("Ext 2 edge did not set its flag");

    edge_polarity_a : assert property (
        edge_hit[0]
        |-> (s_q.pol[0] ? $fell(s_q.sync2[0]) : $rose(s_q.sync2[0])))
    else $error("Edge pulse on the wrong edge");

    edge_single_a : assert property (
        edge_hit[1] && !(reg_wr && reg_addr == ifc_pkg::OFS_CTRL)
        |=> !edge_hit[1])
    else $error("Edge pulse longer than one cycle");

    flag_clear_a : assert property (
        wr_hit[0] && !reg_wdata[14] && !periph_req0[14]
        |=> !s_q.flags[0][14])
    else $error("Flag not cleared by a zero write");

    flag0_sticky_a : assert property (
        s_q.flags[0][1] && !wr_hit[0] |=> s_q.flags[0][1])
    else $error("Flag 0 bit dropped without a write");

    irq_quiet_a : assert property (
        !(|(s_q.flags[0] & s_q.mask[0]))
        && !(|(s_q.flags[1] & s_q.mask[1]))
        && !(|(s_q.flags[2] & s_q.mask[2]))
        |-> !irq)
    else $error("Interrupt raised with nothing unmasked");

endmodule : ifc_flag_ctrl
`default_nettype wire

/* File: sim/ifc_src_model.sv */
// Model of the core status line, the pins and the peripheral sources
`default_nettype none
module ifc_src_model (
    input  wire logic        core_clk,
    output logic             irq_disable_active,
    output logic      [4:0]  ext_irq_pin,
    output logic      [15:0] periph_req0,
    output logic      [15:0] periph_req1,
    output logic      [15:0] periph_req2
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================
    // Idle levels
    initial begin
        irq_disable_active = 1'b0;
        ext_irq_pin = 5'h00;
        periph_req0 = 16'h0000;
        periph_req1 = 16'h0000;
        periph_req2 = 16'h0000;
    end
    // ==================================================
    // Requests are one-cycle pulses, as a real source gives them
    task automatic pulse(input int n, input logic [15:0] v);
        @(posedge core_clk);
        if (n == 0) periph_req0 <= v;
        else if (n == 1) periph_req1 <= v;
        else periph_req2 <= v;
        @(posedge core_clk);
        periph_req0 <= 16'h0000;
        periph_req1 <= 16'h0000;
        periph_req2 <= 16'h0000;
    endtask : pulse
    task automatic set_dis_instr(input logic v);
        @(posedge core_clk);
        irq_disable_active <= v;
    endtask : set_dis_instr
    // Pins stay put long enough for the two-flop synchroniser
    task automatic drive_pin(input int i, input logic v);
        @(posedge core_clk);
        ext_irq_pin[i] <= v;
        repeat (3) @(posedge core_clk);
    endtask : drive_pin
endmodule : ifc_src_model
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the interrupt flag and edge control block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, nrst, reg_wr, reg_rd, alt_sel, irq, dis_act;
    logic [2:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, req0, req1, req2;
    logic [4:0]  pins, edges;
    int          error_cnt, compares;
    // ==================================================
    // Clock and the two units
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    ifc_flag_ctrl dut (.core_clk(core_clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_disable_active(dis_act),
        .alternate_table_select(alt_sel), .irq(irq), .ext_irq_pin(pins),
        .ext_irq_edge(edges), .periph_req0(req0), .periph_req1(req1),
        .periph_req2(req2));
    ifc_src_model src (.core_clk(core_clk), .irq_disable_active(dis_act),
        .ext_irq_pin(pins), .periph_req0(req0), .periph_req1(req1),
        .periph_req2(req2));
    // ==================================================
    // Access tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #5;
        chk(reg_rdata, exp);
    endtask : rd
    // The edge pulse lasts one cycle, so every cycle is looked at
    task automatic pin_edge(input int i, input logic v, input logic exp);
        logic seen;
        seen = 1'b0;
        fork
            src.drive_pin(i, v);
            repeat (6) begin
                @(posedge core_clk);
                #5;
                seen = seen | edges[i];
            end
        join
        chk({15'h0000, seen}, {15'h0000, exp});
    endtask : pin_edge
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        results();
    end
    // ==================================================
    // Main sequence
    initial begin
        logic [15:0] impl [3];
        logic [15:0] hw [3];
        impl = '{16'h7FFF, 16'hFFFB, 16'hDFFF};
        hw = '{16'h7FFE, 16'hDFEB, 16'hDFFF};
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 16'h0000;
        error_cnt = 0;
        compares = 0;
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        for (int a = 0; a < 8; a++) rd(3'(a), 16'h0000);
        wr(ifc_pkg::OFS_CTRL, 16'hFFFF);
        rd(ifc_pkg::OFS_CTRL, 16'h801F);
        chk({15'h0000, alt_sel}, 16'h0001);
        src.set_dis_instr(1'b1);
        rd(ifc_pkg::OFS_CTRL, 16'hC01F);
        src.set_dis_instr(1'b0);
        wr(ifc_pkg::OFS_CTRL, 16'h0000);
        rd(ifc_pkg::OFS_CTRL, 16'h0000);
        chk({15'h0000, alt_sel}, 16'h0000);
        for (int n = 0; n < 3; n++) begin
            wr(ifc_pkg::OFS_FLAGS0 + 3'(n), 16'hFFFF);
            rd(ifc_pkg::OFS_FLAGS0 + 3'(n), impl[n]);
            wr(ifc_pkg::OFS_FLAGS0 + 3'(n), 16'h0000);
            src.pulse(n, 16'hFFFF);
            rd(ifc_pkg::OFS_FLAGS0 + 3'(n), hw[n]);
            rd(ifc_pkg::OFS_FLAGS0 + 3'(n), hw[n]);
        end
        chk({15'h0000, irq}, 16'h0000);
        wr(ifc_pkg::OFS_MASK1, 16'h8000);
        rd(ifc_pkg::OFS_MASK1, 16'h8000);
        chk({15'h0000, irq}, 16'h0001);
        wr(ifc_pkg::OFS_FLAGS1, 16'h5FEB);
        rd(ifc_pkg::OFS_FLAGS1, 16'h5FEB);
        chk({15'h0000, irq}, 16'h0000);
        for (int n = 0; n < 3; n++) wr(ifc_pkg::OFS_FLAGS0 + 3'(n), 16'h0000);
        fork
            src.pulse(2, 16'h8000);
            wr(ifc_pkg::OFS_FLAGS2, 16'h0000);
        join
        rd(ifc_pkg::OFS_FLAGS2, 16'h8000);
        for (int i = 0; i < 5; i++) begin
            wr(ifc_pkg::OFS_CTRL, 16'h0001 << i);
            pin_edge(i, 1'b1, 1'b0);
            pin_edge(i, 1'b0, 1'b1);
            wr(ifc_pkg::OFS_CTRL, 16'h0000);
            pin_edge(i, 1'b1, 1'b1);
            pin_edge(i, 1'b0, 1'b0);
        end
        rd(ifc_pkg::OFS_FLAGS0, 16'h0001);
        rd(ifc_pkg::OFS_FLAGS1, 16'h2010);
        results();
    end
endmodule : tb
`default_nettype wire
